// ===== rwcm_pin_model.sv
// reset pin with its pull-up and an outside reset source.
// assumes: open-drain pin, block drives while oe_n is low.
`timescale 1ns/1ps

module rwcm_pin_model (
  input  wire oe_n,
  input  wire drive_val,
  input  wire ext_low,
  output wire pin
);
  // ========================================================
  // wire level
  // released and undriven reads high, so internal causes show
  assign pin = !oe_n ? drive_val : (ext_low ? 1'b0 : 1'b1);
endmodule

// ===== rwcm_props.sv
// checker on the ports of the reset, watchdog and clock monitor block.
// assumes: one bus clock, reset port asynchronous and active low.
`timescale 1ns/1ps
`include "rwcm_regs.vh"

module rwcm_props #(
  parameter POR_CYCLES = 4064
) (
  input wire        REF_CLK,
  input wire        RESET_N,
  input wire        SPECIAL_MODE,
  input wire        RESET_PIN_IN,
  input wire        RESET_PIN_OE_N,
  input wire        CPU_RESET,
  input wire [15:0] RESET_VECTOR,
  input wire [1:0]  RESET_CAUSE,
  input wire [7:0]  REG_ADDR,
  input wire        REG_RD,
  input wire [7:0]  REG_RDATA
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  // ========================================================
  // cycles since power-on release, saturating
  reg [15:0] cyc;
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N)
      cyc <= 16'h0000;
    else if (cyc != 16'hFFFF)
      cyc <= cyc + 16'h0001;
  end

  // ========================================================
  // properties
  property p_por_hold;
    (cyc < POR_CYCLES) |-> CPU_RESET;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("cpu left power-on reset early");

  property p_drive4;
    $fell(RESET_PIN_OE_N) |-> !RESET_PIN_OE_N [*4] ##1 RESET_PIN_OE_N;
  endproperty
  a_drive4: assert property (p_drive4)
    else $error("pin not driven for four cycles");

  // por also releases the pin, so look only at short drives
  property p_sample;
    $rose(RESET_PIN_OE_N) && $past(RESET_PIN_OE_N, 5) |-> CPU_RESET
      ##1 CPU_RESET ##1 (CPU_RESET == !$past(RESET_PIN_IN));
  endproperty
  a_sample: assert property (p_sample)
    else $error("pin sampled at the wrong cycle");

  property p_trig;
    (!CPU_RESET && !RESET_PIN_IN) |=> (CPU_RESET && !RESET_PIN_OE_N);
  endproperty
  a_trig: assert property (p_trig)
    else $error("low pin did not start a reset");

  property p_hold;
    (CPU_RESET && RESET_PIN_OE_N && !RESET_PIN_IN) |=> CPU_RESET;
  endproperty
  a_hold: assert property (p_hold)
    else $error("reset left while pin low");

  property p_drive_cpu;
    !RESET_PIN_OE_N |-> CPU_RESET;
  endproperty
  a_drive_cpu: assert property (p_drive_cpu)
    else $error("cpu running while pin driven");

  property p_vec;
    $fell(CPU_RESET) && !SPECIAL_MODE |-> RESET_VECTOR ==
      (RESET_CAUSE == `RWCM_CAUSE_EXT ? `RWCM_VEC_EXT_NORM :
       RESET_CAUSE == `RWCM_CAUSE_CMON ? `RWCM_VEC_CMON_NORM :
       `RWCM_VEC_WDOG_NORM);
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector does not match cause");

  property p_stat;
    $past(REG_RD) && ($past(REG_ADDR) == `RWCM_ADDR_STATUS) |->
      REG_RDATA[1:0] == RESET_CAUSE;
  endproperty
  a_stat: assert property (p_stat)
    else $error("status cause differs from cause port");

  c_wdog: cover property ($fell(CPU_RESET) && RESET_CAUSE == 2'h2);
  c_cmon: cover property ($fell(CPU_RESET) && RESET_CAUSE == 2'h1);
  c_ext: cover property ($fell(CPU_RESET) && RESET_CAUSE == 2'h0);
endmodule

bind rwcm_top rwcm_props #(.POR_CYCLES(POR_CYCLES)) rwcm_props_inst (
  .REF_CLK       (REF_CLK),
  .RESET_N       (RESET_N),
  .SPECIAL_MODE  (SPECIAL_MODE),
  .RESET_PIN_IN  (RESET_PIN_IN),
  .RESET_PIN_OE_N(RESET_PIN_OE_N),
  .CPU_RESET     (CPU_RESET),
  .RESET_VECTOR  (RESET_VECTOR),
  .RESET_CAUSE   (RESET_CAUSE),
  .REG_ADDR      (REG_ADDR),
  .REG_RD        (REG_RD),
  .REG_RDATA     (REG_RDATA)
);

// ===== rwcm_regs.vh
// register offsets, field positions, reset values and timing counts
// for the reset, watchdog and clock monitor block.
// assumes: included by bare name, 8-bit register port.
`ifndef RWCM_REGS_VH
`define RWCM_REGS_VH

// ==========================================================
// register offsets
`define RWCM_ADDR_OPTION    8'h39
`define RWCM_ADDR_SERVICE   8'h3A
`define RWCM_ADDR_STATUS    8'h3B
`define RWCM_ADDR_TEST      8'h3E
`define RWCM_ADDR_CONFIG    8'h3F

// ==========================================================
// field positions
`define RWCM_OPT_CME        3
`define RWCM_OPT_RATE_HI    1
`define RWCM_OPT_RATE_LO    0
`define RWCM_TEST_DISABLE_RESETS_BIT      0
`define RWCM_CFG_WATCHDOG_DISABLE_CFG      2

// ==========================================================
// values
`define RWCM_SVC_ARM        8'h55
`define RWCM_SVC_CLEAR      8'hAA
`define RWCM_CFG_ONES       8'h60
`define RWCM_ZERO8          8'h00

// ==========================================================
// reset causes
`define RWCM_CAUSE_EXT      2'h0
`define RWCM_CAUSE_CMON     2'h1
`define RWCM_CAUSE_WDOG     2'h2

// ==========================================================
// vectors
`define RWCM_VEC_EXT_NORM   16'hFFFE
`define RWCM_VEC_CMON_NORM  16'hFFFC
`define RWCM_VEC_WDOG_NORM  16'hFFFA
`define RWCM_VEC_EXT_SPEC   16'hBFFE
`define RWCM_VEC_CMON_SPEC  16'hBFFC
`define RWCM_VEC_WDOG_SPEC  16'hBFFA

// ==========================================================
// timing, in bus clock cycles; the watchdog prescale is a width in bits
`define RWCM_POR_CYCLES     4064
`define RWCM_DRIVE_CYCLES   4
`define RWCM_SAMPLE_DELAY   2
`define RWCM_WRONCE_CYCLES  64
`define RWCM_WD_PRESCALE    15

`endif

// ===== rwcm_top.v
// reset sequencer, watchdog control and clock monitor.
// assumes: REF_CLK is the bus clock; pin and strap inputs are
// synchronous; the rc delay cell flags missing clock edges itself.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "rwcm_regs.vh"

module rwcm_top #(
  parameter POR_CYCLES       = `RWCM_POR_CYCLES,
  parameter WD_PRESCALE_BITS = `RWCM_WD_PRESCALE,
  parameter WATCHDOG_DISABLE_CFG_DEFAULT    = 1'b0
) (
  input  wire        REF_CLK,
  input  wire        RESET_N,
  input  wire        SPECIAL_MODE,
  input  wire        STOP_MODE,
  input  wire        RC_DELAY_EXPIRED,
  input  wire        RESET_PIN_IN,
  output wire        RESET_PIN_OUT,
  output wire        RESET_PIN_OE_N,
  output wire        CPU_RESET,
  output reg  [15:0] RESET_VECTOR,
  output reg  [1:0]  RESET_CAUSE,
  input  wire [7:0]  REG_ADDR,
  input  wire [7:0]  REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output reg  [7:0]  REG_RDATA
);

  // ==========================================================
  // state codes
  localparam ST_POR     = 3'h0;
  localparam ST_PINHOLD = 3'h1;
  localparam ST_DRIVE   = 3'h2;
  localparam ST_RELEASE = 3'h3;
  localparam ST_RUN     = 3'h4;

  localparam [11:0] POR_LAST   = POR_CYCLES - 1;
  localparam [2:0]  DRIVE_LAST = `RWCM_DRIVE_CYCLES - 1;
  localparam [2:0]  SAMP_LAST  = `RWCM_SAMPLE_DELAY - 1;
  localparam [6:0]  WRONCE_END = `RWCM_WRONCE_CYCLES;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [11:0] por_count;
  reg  [2:0]  seq_count;
  reg  [1:0]  pend_cause;
  reg  [1:0]  next_cause;
  reg         clock_monitor_en;
  reg  [1:0]  rate_sel;
  reg         rate_written;
  reg  [6:0]  since_reset;
  reg         disable_resets_bit;
  reg         watchdog_disable_cfg_latch;
  reg         watchdog_disable_cfg_shadow;
  reg         armed;
  wire        sys_rst;
  wire        run;
  wire        wd_timeout;
  wire        cm_fail;
  wire        wr_opt;
  wire        wr_svc;
  wire        svc_clear;
  wire        rate_open;
  wire        wd_enable;
  wire        trig;

  // ==========================================================
  // reset sequencer
  assign run       = (state == ST_RUN);
  assign sys_rst   = !run;
  assign CPU_RESET = sys_rst;
  // pin driven low in the drive window and during the power-on count
  assign RESET_PIN_OUT  = 1'b0;
  assign RESET_PIN_OE_N = !(state == ST_DRIVE || state == ST_POR);

  // monitor sees both a dead clock and clocks halted by stop
  assign cm_fail = clock_monitor_en && (RC_DELAY_EXPIRED || STOP_MODE);
  assign trig    = !RESET_PIN_IN || wd_timeout || cm_fail;

  always @* begin
    next_state = state;
    next_cause = pend_cause;
    case (state)
      ST_POR: begin
        if (por_count == POR_LAST) begin
          if (RESET_PIN_IN) begin
            next_state = ST_RUN;
          end else begin
            next_state = ST_PINHOLD;
          end
          next_cause = `RWCM_CAUSE_EXT;
        end
      end
      ST_PINHOLD: begin
        if (RESET_PIN_IN) begin
          next_state = ST_RUN;
        end
      end
      ST_DRIVE: begin
        if (seq_count == DRIVE_LAST) begin
          next_state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (seq_count == SAMP_LAST) begin
          if (RESET_PIN_IN) begin
            next_state = ST_RUN;
          end else begin
            next_state = ST_PINHOLD;
            next_cause = `RWCM_CAUSE_EXT;
          end
        end
      end
      ST_RUN: begin
        if (trig) begin
          next_state = ST_DRIVE;
          // monitor outranks watchdog if both fire together
          if (cm_fail) begin
            next_cause = `RWCM_CAUSE_CMON;
          end else if (wd_timeout) begin
            next_cause = `RWCM_CAUSE_WDOG;
          end else begin
            next_cause = `RWCM_CAUSE_EXT;
          end
        end
      end
      default: begin
        next_state = ST_POR;
      end
    endcase
  end

  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state      <= ST_POR;
      por_count  <= 12'h000;
      seq_count  <= 3'h0;
      pend_cause <= `RWCM_CAUSE_EXT;
    end else begin
      state      <= next_state;
      pend_cause <= next_cause;
      if (state == ST_POR) begin
        por_count <= por_count + 12'h001;
      end
      if (next_state != state) begin
        seq_count <= 3'h0;
      end else begin
        seq_count <= seq_count + 3'h1;
      end
    end
  end

  // vector and cause shown at reset exit, held while running
  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RESET_VECTOR <= `RWCM_VEC_EXT_NORM;
      RESET_CAUSE  <= `RWCM_CAUSE_EXT;
    end else if (!run && next_state == ST_RUN) begin
      RESET_CAUSE <= next_cause;
      case (next_cause)
        `RWCM_CAUSE_CMON: RESET_VECTOR <= SPECIAL_MODE ?
          `RWCM_VEC_CMON_SPEC : `RWCM_VEC_CMON_NORM;
        `RWCM_CAUSE_WDOG: RESET_VECTOR <= SPECIAL_MODE ?
          `RWCM_VEC_WDOG_SPEC : `RWCM_VEC_WDOG_NORM;
        default: RESET_VECTOR <= SPECIAL_MODE ?
          `RWCM_VEC_EXT_SPEC : `RWCM_VEC_EXT_NORM;
      endcase
    end
  end

  // ==========================================================
  // register port
  assign wr_opt    = run && REG_WR && (REG_ADDR == `RWCM_ADDR_OPTION);
  assign wr_svc    = run && REG_WR && (REG_ADDR == `RWCM_ADDR_SERVICE);
  assign svc_clear = wr_svc && armed && (REG_WDATA == `RWCM_SVC_CLEAR);
  assign rate_open = SPECIAL_MODE ||
                     (!rate_written && since_reset < WRONCE_END);
  assign wd_enable = !watchdog_disable_cfg_latch && !disable_resets_bit;

  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      clock_monitor_en          <= 1'b0;
      rate_sel     <= 2'h0;
      rate_written <= 1'b0;
      since_reset  <= 7'h00;
      disable_resets_bit         <= 1'b0;
      armed        <= 1'b0;
      watchdog_disable_cfg_shadow <= WATCHDOG_DISABLE_CFG_DEFAULT;
      watchdog_disable_cfg_latch  <= WATCHDOG_DISABLE_CFG_DEFAULT;
    end else if (sys_rst) begin
      clock_monitor_en          <= 1'b0;
      rate_sel     <= 2'h0;
      rate_written <= 1'b0;
      since_reset  <= 7'h00;
      disable_resets_bit         <= SPECIAL_MODE;
      armed        <= 1'b0;
      watchdog_disable_cfg_latch  <= watchdog_disable_cfg_shadow;
    end else begin
      if (since_reset != WRONCE_END) begin
        since_reset <= since_reset + 7'h01;
      end
      if (wr_opt) begin
        clock_monitor_en <= REG_WDATA[`RWCM_OPT_CME];
        if (rate_open) begin
          rate_sel     <= REG_WDATA[`RWCM_OPT_RATE_HI:`RWCM_OPT_RATE_LO];
          rate_written <= 1'b1;
        end
      end
      if (wr_svc && REG_WDATA == `RWCM_SVC_ARM) begin
        armed <= 1'b1;
      end else if (svc_clear) begin
        armed <= 1'b0;
      end
      if (REG_WR && REG_ADDR == `RWCM_ADDR_TEST) begin
        disable_resets_bit <= REG_WDATA[`RWCM_TEST_DISABLE_RESETS_BIT];
      end
      // stored copy only; the live latch reloads at the next reset
      if (REG_WR && REG_ADDR == `RWCM_ADDR_CONFIG) begin
        watchdog_disable_cfg_shadow <= REG_WDATA[`RWCM_CFG_WATCHDOG_DISABLE_CFG];
      end
    end
  end

  always @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA <= `RWCM_ZERO8;
    end else if (REG_RD) begin
      case (REG_ADDR)
        `RWCM_ADDR_OPTION:
          REG_RDATA <= {4'h0, clock_monitor_en, 1'b0, rate_sel};
        `RWCM_ADDR_STATUS:
          REG_RDATA <= {5'h00, sys_rst, RESET_CAUSE};
        `RWCM_ADDR_TEST:
          REG_RDATA <= {7'h00, disable_resets_bit};
        `RWCM_ADDR_CONFIG:
          REG_RDATA <= `RWCM_CFG_ONES | {5'h00, watchdog_disable_cfg_latch, 2'h0};
        default:
          REG_RDATA <= `RWCM_ZERO8;
      endcase
    end else begin
      REG_RDATA <= `RWCM_ZERO8;
    end
  end

  // ==========================================================
  // watchdog
  // stop halts its count; a dead clock is left to the monitor
  rwcm_wdog #(
    .PRESCALE_BITS (WD_PRESCALE_BITS)
  ) u_wdog (
    .clk      (REF_CLK),
    .rst_n    (RESET_N),
    .sys_rst  (sys_rst),
    .run      (!STOP_MODE),
    .service  (svc_clear),
    .enable   (wd_enable),
    .rate_sel (rate_sel),
    .timeout  (wd_timeout)
  );

  // frequency thresholds of the monitor live in the rc cell;
  // at the 10 MHz bus clock it never flags

endmodule

// ===== rwcm_wdog.v
// watchdog prescaler and timeout counter.
// assumes: one bus clock, sync clear from the reset sequencer.
`timescale 1ns/1ps
`include "rwcm_regs.vh"

module rwcm_wdog #(
  parameter PRESCALE_BITS = `RWCM_WD_PRESCALE
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       sys_rst,
  input  wire       run,
  input  wire       service,
  input  wire       enable,
  input  wire [1:0] rate_sel,
  output reg        timeout
);

  reg  [PRESCALE_BITS-1:0] prescale;
  reg  [6:0]               ticks;
  reg  [6:0]               limit;
  wire                     tick;

  // ==========================================================
  // prescaler
  assign tick = &prescale;

  // rate factor 1/4/16/64; one extra tick makes the error -0/+1 tick
  always @* begin
    case (rate_sel)
      2'h0:    limit = 7'h01;
      2'h1:    limit = 7'h04;
      2'h2:    limit = 7'h10;
      2'h3:    limit = 7'h40;
      default: limit = 7'h01;
    endcase
  end

  // prescaler free-runs across services, cleared only by reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= {PRESCALE_BITS{1'b0}};
      ticks    <= 7'h00;
      timeout  <= 1'b0;
    end else if (sys_rst) begin
      prescale <= {PRESCALE_BITS{1'b0}};
      ticks    <= 7'h00;
      timeout  <= 1'b0;
    end else if (run) begin // halted clocks halt the count
      prescale <= prescale + {{(PRESCALE_BITS-1){1'b0}}, 1'b1};
      timeout  <= 1'b0;
      if (service) begin
        ticks <= 7'h00;
      end else if (tick) begin
        if (ticks == limit) begin
          ticks   <= 7'h00;
          timeout <= enable;
        end else begin
          ticks <= ticks + 7'h01;
        end
      end
    end else begin
      timeout <= 1'b0;
    end
  end

endmodule

// ===== testbench.sv
// self-checking bench for the reset, watchdog and clock monitor block.
// assumes: short counts (por 16, prescaler 2^4) set at the instance.
`timescale 1ns/1ps
`include "rwcm_regs.vh"

module testbench;
  reg         ref_clk;
  reg         reset_n;
  reg         special_mode;
  reg         stop_mode;
  reg         rc_expired;
  reg         ext_low;
  reg         reg_wr;
  reg         reg_rd;
  reg  [7:0]  reg_addr;
  reg  [7:0]  reg_wdata;
  wire        pin;
  wire        pin_out;
  wire        pin_oe_n;
  wire        cpu_reset;
  wire [15:0] vec;
  wire [1:0]  cause;
  wire [7:0]  rdata;
  integer     fail_count;
  integer     check_count;
  integer     n;
  time        t0;

  rwcm_top #(.POR_CYCLES(16), .WD_PRESCALE_BITS(4)) rwcm_top_inst (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .SPECIAL_MODE(special_mode),
    .STOP_MODE(stop_mode), .RC_DELAY_EXPIRED(rc_expired),
    .RESET_PIN_IN(pin), .RESET_PIN_OUT(pin_out),
    .RESET_PIN_OE_N(pin_oe_n), .CPU_RESET(cpu_reset),
    .RESET_VECTOR(vec), .RESET_CAUSE(cause), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(rdata));

  rwcm_pin_model rwcm_pin_model_inst (.oe_n(pin_oe_n),
    .drive_val(pin_out), .ext_low(ext_low), .pin(pin));

  // ========================================================
  // clock, watchdog on the run
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    #(20000 * 100);
    fail_count = fail_count + 1;
    wrap_up;
  end

  // ========================================================
  // tasks
  task chk(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // gap cycle after each strobe keeps one assignment per time step
  task wr(input [7:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
    end
  endtask

  task rd(input [7:0] a, input [7:0] exp);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk({8'h00, rdata}, {8'h00, exp});
      @(posedge ref_clk);
    end
  endtask

  task wait_lvl(input v, input integer lim);
    begin
      n = 0;
      while (cpu_reset !== v && n < lim) begin
        @(posedge ref_clk);
        #1;
        n = n + 1;
      end
      chk({15'h0000, cpu_reset}, {15'h0000, v});
      @(posedge ref_clk);
    end
  endtask

  task wrap_up;
    begin
      if (fail_count == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // ========================================================
  // scenarios
  initial begin
    fail_count = 0;
    check_count = 0;
    reset_n = 1'b0;
    special_mode = 1'b0;
    stop_mode = 1'b0;
    rc_expired = 1'b0;
    ext_low = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (40) @(posedge ref_clk);
    ext_low <= 1'b0;
    #1;
    chk({15'h0000, cpu_reset}, 16'h0001);
    wait_lvl(1'b0, 20);
    wr(`RWCM_ADDR_OPTION, 8'h0B);
    wr(`RWCM_ADDR_SERVICE, `RWCM_SVC_ARM);
    wr(`RWCM_ADDR_SERVICE, `RWCM_SVC_CLEAR);
    rd(`RWCM_ADDR_OPTION, 8'h0B);
    wr(`RWCM_ADDR_OPTION, 8'h01);
    rd(`RWCM_ADDR_OPTION, 8'h03);
    rd(`RWCM_ADDR_SERVICE, 8'h00);
    rd(`RWCM_ADDR_CONFIG, 8'h60);
    wr(`RWCM_ADDR_CONFIG, 8'h64);
    rd(`RWCM_ADDR_CONFIG, 8'h60);
    repeat (3) begin
      wr(`RWCM_ADDR_SERVICE, `RWCM_SVC_ARM);
      repeat (400) @(posedge ref_clk);
      wr(`RWCM_ADDR_SERVICE, `RWCM_SVC_CLEAR);
      chk({15'h0000, cpu_reset}, 16'h0000);
    end
    t0 = $time;
    repeat (500) @(posedge ref_clk);
    wr(`RWCM_ADDR_SERVICE, `RWCM_SVC_CLEAR);
    wait_lvl(1'b1, 700);
    n = ($time - t0) / 100;
    chk({15'h0000, (n >= 1020 && n <= 1046)}, 16'h0001);
    chk({14'h0000, pin_oe_n, pin_out}, 16'h0000);
    wait_lvl(1'b0, 20);
    chk(vec, `RWCM_VEC_WDOG_NORM);
    chk({14'h0000, cause}, {14'h0000, `RWCM_CAUSE_WDOG});
    rd(`RWCM_ADDR_STATUS, 8'h02);
    rd(`RWCM_ADDR_CONFIG, 8'h64);
    rd(`RWCM_ADDR_OPTION, 8'h00);
    repeat (100) @(posedge ref_clk);
    chk({15'h0000, cpu_reset}, 16'h0000);
    wr(`RWCM_ADDR_OPTION, 8'h08);
    rc_expired <= 1'b1;
    @(posedge ref_clk);
    rc_expired <= 1'b0;
    wait_lvl(1'b1, 5);
    wait_lvl(1'b0, 20);
    chk(vec, `RWCM_VEC_CMON_NORM);
    rd(`RWCM_ADDR_OPTION, 8'h00);
    stop_mode <= 1'b1;
    repeat (50) @(posedge ref_clk);
    chk({15'h0000, cpu_reset}, 16'h0000);
    stop_mode <= 1'b0;
    wr(`RWCM_ADDR_OPTION, 8'h08);
    stop_mode <= 1'b1;
    wait_lvl(1'b1, 5);
    stop_mode <= 1'b0;
    wait_lvl(1'b0, 20);
    rd(`RWCM_ADDR_STATUS, 8'h01);
    ext_low <= 1'b1;
    wait_lvl(1'b1, 5);
    repeat (10) @(posedge ref_clk);
    ext_low <= 1'b0;
    wait_lvl(1'b0, 20);
    chk(vec, `RWCM_VEC_EXT_NORM);
    rd(`RWCM_ADDR_STATUS, 8'h00);
    wr(`RWCM_ADDR_CONFIG, 8'h60);
    special_mode <= 1'b1;
    reset_n <= 1'b0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    wait_lvl(1'b0, 40);
    rd(`RWCM_ADDR_TEST, 8'h01);
    repeat (100) @(posedge ref_clk);
    chk({15'h0000, cpu_reset}, 16'h0000);
    wr(`RWCM_ADDR_TEST, 8'h00);
    wait_lvl(1'b1, 40);
    wait_lvl(1'b0, 20);
    chk(vec, `RWCM_VEC_WDOG_SPEC);
    wrap_up;
  end
endmodule
